// File: psrbs_pkg.sv
// Constants, register map and types for the preset speed, ramp and brake selector.
package psrbs_pkg;
  localparam int unsigned NREG = 33;
  localparam logic [5:0] IDX_PRESET0 = 6'h00;
  localparam logic [5:0] IDX_TARGET0 = 6'h08;
  localparam logic [5:0] IDX_SPEED_REF = 6'h10;
  localparam logic [5:0] IDX_POS_MODE = 6'h11;
  localparam logic [5:0] IDX_DI1_FN = 6'h12;
  localparam logic [5:0] IDX_ACCEL1 = 6'h15;
  localparam logic [5:0] IDX_DECEL1 = 6'h16;
  localparam logic [5:0] IDX_ACCEL2 = 6'h17;
  localparam logic [5:0] IDX_DECEL2 = 6'h18;
  localparam logic [5:0] IDX_JOG_FREQ = 6'h19;
  localparam logic [5:0] IDX_JOG_RAMP = 6'h1A;
  localparam logic [5:0] IDX_MAX_FREQ = 6'h1B;
  localparam logic [5:0] IDX_DC_DUR = 6'h1C;
  localparam logic [5:0] IDX_DC_LEVEL = 6'h1D;
  localparam logic [5:0] IDX_STOP_MODE = 6'h1E;
  localparam logic [5:0] IDX_DB_SEL = 6'h1F;
  localparam logic [5:0] IDX_SCURVE = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;
  localparam logic [7:0] DI_FN_PRESET = 8'h04;
  localparam logic [7:0] DI_FN_RAMP2 = 8'h05;
  localparam logic [7:0] SREF_PRESET = 8'h04;
  localparam logic [7:0] SREF_POSITION = 8'h09;
  localparam logic [7:0] POSM_PRESET = 8'h01;
  localparam logic [7:0] STOP_RAMP = 8'h04;
  localparam logic [7:0] STOP_DC = 8'h06;
  localparam logic [15:0] DC_CONTINUOUS = 16'h03E7;
  localparam logic [7:0] DB_OFF = 8'h00;
  localparam logic [7:0] DB_NORMAL = 8'h01;
  localparam logic [7:0] DB_NOPROT = 8'h02;
  localparam logic [7:0] DB_PCT_MAX = 8'h63;
  localparam logic [6:0] DB_NORMAL_DUTY = 7'h05;
  localparam logic [6:0] DB_FULL_DUTY = 7'h64;
  localparam logic [6:0] SCURVE_MAX = 7'h64;
  localparam logic [15:0] JOG_RAMP_MIN = 16'h0001;
  localparam logic [22:0] S_HALF_DIV = 23'h0000C8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned BRAKE_STEP_NS = 100000000;
  localparam int unsigned BRAKE_STEP_CYCLES = BRAKE_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned ST_INDEX_LSB = 0;
  localparam int unsigned ST_RAMP2 = 3;
  localparam int unsigned ST_PRESET_MODE = 4;
  localparam int unsigned ST_POS_MODE = 5;
  localparam int unsigned ST_JOG = 6;
  localparam int unsigned ST_BRAKE = 7;
  localparam int unsigned ST_DB_PROTECT = 8;
  localparam int unsigned ST_FREQ_LSB = 16;
  localparam logic [31:0] CFG_MASK [0:NREG-1] = '{
    32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h000000FF, 32'h000000FF, 32'h000000FF, 32'h000000FF, 32'h000000FF,
    32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF,
    32'h000000FF, 32'h000000FF, 32'h0000007F};
  localparam logic [31:0] CFG_RST [0:NREG-1] = '{
    32'h00000000, 32'h000001F4, 32'h000003E8, 32'h000007D0,
    32'h00000BB8, 32'h00000FA0, 32'h00001388, 32'h00001770,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000064, 32'h00000064, 32'h000000C8, 32'h000000C8,
    32'h000003E8, 32'h00000064, 32'h00001770, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000};
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_TIMED = 2'b01,
    BRK_HOLD = 2'b10
  } psrbs_brk_t;
endpackage

// File: psrbs_top.sv
// Preset speed and position selector with ramp shaping, DC injection and dynamic brake decode.
// How it works
// - In velocity operation presets drive speed only with speed reference option 4.
// - Position presets apply only with speed reference 9 and positioning mode 1.
// - Inputs 1..3 form index LSB first; each counts only with function 4.
// - Indexes 0,1,4,5 use ramp set 1; 2,3,6,7 use set 2.
// - Any active input set to second-ramp select forces ramp set 2.
// - Jog drives output to jog frequency, default 10.00 Hz, capped at maximum.
// - Jog uses one ramp time for both directions, 0.1 to 600.0 s; here only the 0.1 s floor is enforced.
// - DC injection lasts programmed tenths of a second; 99.9 means continuous.
// - DC brake level applies only with stop mode option 4 or 6.
// - Resistor selector: 0 off, 1 at 5%, 2 at 100%, 3..99 that percent.
// - Resistor overload protection runs only when the selector equals 1.
// - S-curve adds its percentage of ramp time, half at start, half at end.
// - S-curve defaults to 0 percent, meaning linear ramps with no added time.
// - An active preset selection wins over the other speed command sources; here an active jog still overrides it.
// - Ramp set 2 covers all speed changes except jog.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module psrbs_top
  import psrbs_pkg::*;
#(
  parameter int unsigned BRAKE_STEP = psrbs_pkg::BRAKE_STEP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] digital_in,
  input wire logic jog_cmd,
  input wire logic [15:0] ext_freq_cmd,
  input wire logic brake_start,
  input wire logic brake_release,
  output var logic [15:0] freq_cmd_r,
  output var logic [31:0] position_target_r,
  output var logic position_valid_r,
  output var logic [2:0] preset_index_r,
  output var logic ramp_set2_r,
  output var logic [15:0] accel_time_r,
  output var logic [15:0] decel_time_r,
  output var logic [15:0] s_half_accel_r,
  output var logic [15:0] s_half_decel_r,
  output var logic dc_brake_active_r,
  output var logic [15:0] dc_brake_level_r,
  output var logic db_enable_r,
  output var logic [6:0] db_duty_limit_r,
  output var logic db_overload_protect_r
);
  import psrbs_pkg::*;

  logic [31:0] cfg_r [0:NREG-1];
  logic [31:0] cfg_nxt [0:NREG-1];
  logic awready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt, status_w;
  logic [5:0] widx, ridx;
  logic [2:0] di_r, idx_bit, r2_bit;
  logic [2:0] index_w;
  logic preset_mode_w, pos_mode_w, ramp2_w;
  logic [15:0] max_freq_w, jog_freq_w, jog_ramp_w, accel_w, decel_w, freq_w;
  logic [6:0] scurve_w, duty_w;
  logic [22:0] prod_a, prod_d;
  logic [7:0] db_sel_w, stop_mode_w;
  psrbs_brk_t brk_r, brk_nxt;
  logic [15:0] brk_cnt_r, brk_cnt_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_w;

  assign widx = s_axi_awaddr[7:2];
  assign ridx = s_axi_araddr[7:2];

  // Write address and data are taken together in one cycle so that no half-taken write exists.
  always_comb begin
    awready_nxt = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    bvalid_nxt = s_axi_bvalid && !s_axi_bready;
    bresp_nxt = s_axi_bresp;
    for (int i = 0; i < NREG; i++) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (s_axi_awready) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (widx > IDX_STATUS) ? RESP_SLVERR : RESP_OKAY;
      if (widx < IDX_STATUS) begin
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            cfg_nxt[widx][8*b +: 8] = s_axi_wdata[8*b +: 8] & CFG_MASK[widx][8*b +: 8];
          end
        end
      end
    end
  end

  // Reads past the status word answer with an error and zero data.
  always_comb begin
    arready_nxt = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    rvalid_nxt = s_axi_rvalid && !s_axi_rready;
    rresp_nxt = s_axi_rresp;
    rdata_nxt = s_axi_rdata;
    if (s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      if (ridx == IDX_STATUS) begin
        rdata_nxt = status_w;
      end else if (ridx < IDX_STATUS) begin
        rdata_nxt = cfg_r[ridx];
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      for (int i = 0; i < NREG; i++) begin
        cfg_r[i] <= CFG_RST[i];
      end
    end else begin
      s_axi_awready <= awready_nxt;
      s_axi_wready <= awready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
      for (int i = 0; i < NREG; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  // Each input is qualified by its own function code.
  for (genvar g = 0; g < 3; g++) begin : g_di
    assign idx_bit[g] = di_r[g] && (cfg_r[int'(IDX_DI1_FN) + g][7:0] == DI_FN_PRESET);
    assign r2_bit[g] = di_r[g] && (cfg_r[int'(IDX_DI1_FN) + g][7:0] == DI_FN_RAMP2);
  end

  // Status shows the registered selection, so software sees what the outputs carry.
  assign status_w = {freq_cmd_r, 7'h00, db_overload_protect_r, dc_brake_active_r, jog_cmd,
    position_valid_r, preset_mode_w, ramp_set2_r, preset_index_r};

  always_comb begin
    index_w = idx_bit;
    preset_mode_w = (cfg_r[IDX_SPEED_REF][7:0] == SREF_PRESET);
    pos_mode_w = (cfg_r[IDX_SPEED_REF][7:0] == SREF_POSITION)
      && (cfg_r[IDX_POS_MODE][7:0] == POSM_PRESET);
    ramp2_w = index_w[1] || (|r2_bit);
    max_freq_w = cfg_r[IDX_MAX_FREQ][15:0];
    jog_freq_w = cfg_r[IDX_JOG_FREQ][15:0];
    if (jog_freq_w > max_freq_w) begin
      jog_freq_w = max_freq_w;
    end
    jog_ramp_w = cfg_r[IDX_JOG_RAMP][15:0];
    if (jog_ramp_w < JOG_RAMP_MIN) begin
      jog_ramp_w = JOG_RAMP_MIN;
    end
    if (jog_cmd) begin
      freq_w = jog_freq_w;
      accel_w = jog_ramp_w;
      decel_w = jog_ramp_w;
    end else begin
      freq_w = preset_mode_w ? cfg_r[int'(IDX_PRESET0) + int'(index_w)][15:0]
        : ext_freq_cmd;
      accel_w = ramp2_w ? cfg_r[IDX_ACCEL2][15:0] : cfg_r[IDX_ACCEL1][15:0];
      decel_w = ramp2_w ? cfg_r[IDX_DECEL2][15:0] : cfg_r[IDX_DECEL1][15:0];
    end
    // A setting from 101 to 127 is treated as the top; the write mask keeps only 7 bits, so a write of 128 or more wraps.
    scurve_w = cfg_r[IDX_SCURVE][6:0];
    if (scurve_w > SCURVE_MAX) begin
      scurve_w = SCURVE_MAX;
    end
    prod_a = 23'(accel_w) * 23'(scurve_w);
    prod_d = 23'(decel_w) * 23'(scurve_w);
    db_sel_w = cfg_r[IDX_DB_SEL][7:0];
    // The selector is applied as written; changing it mid-run is left to the host.
    if (db_sel_w == DB_OFF) begin
      duty_w = 7'h00;
    end else if (db_sel_w == DB_NORMAL) begin
      duty_w = DB_NORMAL_DUTY;
    end else if (db_sel_w == DB_NOPROT || db_sel_w > DB_PCT_MAX) begin
      duty_w = DB_FULL_DUTY;
    end else begin
      duty_w = db_sel_w[6:0];
    end
    stop_mode_w = cfg_r[IDX_STOP_MODE][7:0];
  end

  // One register stage for all selection outputs keeps index and ramp set in step.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      di_r <= 3'h0;
      freq_cmd_r <= 16'h0000;
      position_target_r <= 32'h00000000;
      position_valid_r <= 1'b0;
      preset_index_r <= 3'h0;
      ramp_set2_r <= 1'b0;
      accel_time_r <= 16'h0000;
      decel_time_r <= 16'h0000;
      s_half_accel_r <= 16'h0000;
      s_half_decel_r <= 16'h0000;
      dc_brake_level_r <= 16'h0000;
      db_enable_r <= 1'b0;
      db_duty_limit_r <= 7'h00;
      db_overload_protect_r <= 1'b0;
    end else begin
      di_r <= digital_in;
      freq_cmd_r <= freq_w;
      position_target_r <= cfg_r[int'(IDX_TARGET0) + int'(index_w)];
      position_valid_r <= pos_mode_w;
      preset_index_r <= index_w;
      ramp_set2_r <= ramp2_w && !jog_cmd;
      accel_time_r <= accel_w;
      decel_time_r <= decel_w;
      s_half_accel_r <= 16'(prod_a / S_HALF_DIV);
      s_half_decel_r <= 16'(prod_d / S_HALF_DIV);
      // The level is forced to zero so a stale level never reaches the current loop.
      dc_brake_level_r <= ((stop_mode_w == STOP_RAMP) || (stop_mode_w == STOP_DC))
        ? cfg_r[IDX_DC_LEVEL][15:0] : 16'h0000;
      db_enable_r <= (db_sel_w != DB_OFF);
      db_duty_limit_r <= duty_w;
      db_overload_protect_r <= (db_sel_w == DB_NORMAL);
    end
  end

  // The tenth-second divider runs only while timing, so each step is a full tenth.
  assign tick_w = (tick_cnt_r == 32'(BRAKE_STEP - 1));

  always_comb begin
    brk_nxt = brk_r;
    brk_cnt_nxt = brk_cnt_r;
    tick_cnt_nxt = 32'h00000000;
    unique case (brk_r)
      BRK_IDLE: begin
        // A zero duration leaves the brake idle, so a start request is then ignored.
        if (brake_start && cfg_r[IDX_DC_DUR][15:0] != 16'h0000) begin
          brk_cnt_nxt = cfg_r[IDX_DC_DUR][15:0];
          brk_nxt = (cfg_r[IDX_DC_DUR][15:0] >= DC_CONTINUOUS) ? BRK_HOLD : BRK_TIMED;
        end
      end
      BRK_TIMED: begin
        tick_cnt_nxt = tick_w ? 32'h00000000 : tick_cnt_r + 32'h00000001;
        if (tick_w) begin
          brk_cnt_nxt = brk_cnt_r - 16'h0001;
        end
        if (brake_release || (tick_w && brk_cnt_r == 16'h0001)) begin
          brk_nxt = BRK_IDLE;
        end
      end
      BRK_HOLD: begin
        // A hold has no time limit; only a release ends it.
        if (brake_release) begin
          brk_nxt = BRK_IDLE;
        end
      end
      default: begin
        brk_nxt = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_r <= BRK_IDLE;
      brk_cnt_r <= 16'h0000;
      tick_cnt_r <= 32'h00000000;
      dc_brake_active_r <= 1'b0;
    end else begin
      brk_r <= brk_nxt;
      brk_cnt_r <= brk_cnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      dc_brake_active_r <= (brk_nxt != BRK_IDLE);
    end
  end
endmodule
`default_nettype wire

// File: psrbs_checker.sv
// Concurrent checks on the ports of the preset, ramp and brake selector.
`timescale 1ns/1ps
`default_nettype none
module psrbs_checker
  import psrbs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic jog_cmd,
  input wire logic brake_start,
  input wire logic brake_release,
  input wire logic ramp_set2_r,
  input wire logic [15:0] accel_time_r,
  input wire logic [15:0] decel_time_r,
  input wire logic [15:0] s_half_accel_r,
  input wire logic [15:0] s_half_decel_r,
  input wire logic dc_brake_active_r,
  input wire logic db_enable_r,
  input wire logic [6:0] db_duty_limit_r,
  input wire logic db_overload_protect_r
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  db_protect_a: assert property (
    db_overload_protect_r |-> db_enable_r && db_duty_limit_r == DB_NORMAL_DUTY)
    else $error("overload protection without normal resistor duty");
  db_duty_a: assert property (
    db_enable_r |-> db_duty_limit_r >= 7'h03 && db_duty_limit_r <= DB_FULL_DUTY)
    else $error("brake duty limit outside decoded range");
  jog_set1_a: assert property (
    $past(jog_cmd) |-> !ramp_set2_r)
    else $error("second ramp set used during jog");
  jog_ramp_a: assert property (
    $past(jog_cmd) |-> accel_time_r == decel_time_r && accel_time_r != 16'h0000)
    else $error("jog ramp differs between directions");
  s_accel_a: assert property (
    s_half_accel_r <= (accel_time_r >> 1))
    else $error("accel S-curve half exceeds half the ramp");
  s_decel_a: assert property (
    s_half_decel_r <= (decel_time_r >> 1))
    else $error("decel S-curve half exceeds half the ramp");
  brk_cause_a: assert property (
    $rose(dc_brake_active_r) |-> $past(brake_start))
    else $error("injection began without a start request");
  brk_end_a: assert property (
    brake_release && !brake_start |=> !dc_brake_active_r)
    else $error("injection did not end on release");
  cover property ($past(jog_cmd) && accel_time_r != 16'h0000);
  cover property ($rose(dc_brake_active_r));
  cover property (db_overload_protect_r);
endmodule
`default_nettype wire

// File: psrbs_contacts.sv
// Behavioural model of the selection contacts and jog switch wired to the drive.
`timescale 1ns/1ps
`default_nettype none
module psrbs_contacts (
  input wire logic aclk,
  input wire logic [2:0] want,
  input wire logic jog_want,
  output logic [2:0] contacts = 3'h0,
  output logic jog = 1'b0
);
  // Contacts move just after an edge, so the drive never sees a half-changed index.
  always @(posedge aclk) begin
    contacts <= want;
    jog <= jog_want;
  end
endmodule
`default_nettype wire

// File: psrbs_top_tb.sv
// Self-checking bench for the preset, ramp and brake selector.
`timescale 1ns/1ps
`default_nettype none
module psrbs_top_tb;
  import psrbs_pkg::*;
  localparam int BRK = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, ptgt, tv;
  logic [2:0] want = 3'h0, din, pidx;
  logic jog_want = 1'b0, jog, bstart = 1'b0, brel = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pval, r2, dca, dben, dbp;
  logic [1:0] bresp, rresp;
  logic [15:0] ext = 16'h0, freq, acc, dec, sha, shd, lvl, lv;
  logic [6:0] duty;
  logic [15:0] pv [0:7];
  logic [7:0] ds [0:5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h39, 8'h63};
  logic [65:0] qr [$];
  logic [65:0] re;
  logic [1:0] qb [$];
  int n_mismatch = 0;
  int n_checks = 0;
  int r, s, cnt;
  always #2.5 aclk = ~aclk;
  psrbs_top #(.BRAKE_STEP(BRK)) psrbs_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .digital_in(din), .jog_cmd(jog), .ext_freq_cmd(ext),
    .brake_start(bstart), .brake_release(brel), .freq_cmd_r(freq), .position_target_r(ptgt),
    .position_valid_r(pval), .preset_index_r(pidx), .ramp_set2_r(r2), .accel_time_r(acc),
    .decel_time_r(dec), .s_half_accel_r(sha), .s_half_decel_r(shd), .dc_brake_active_r(dca),
    .dc_brake_level_r(lvl), .db_enable_r(dben), .db_duty_limit_r(duty),
    .db_overload_protect_r(dbp));
  psrbs_contacts psrbs_contacts_i (.aclk(aclk), .want(want), .jog_want(jog_want),
    .contacts(din), .jog(jog));
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      n_mismatch++;
      $display("Error at %0t: bus wait timed out", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = RESP_OKAY);
    int n;
    logic aw, w;
    qb.push_back(rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    while ((aw || w) && n < 200) begin
      @(posedge aclk);
      n++;
      aw = aw & ~awready;
      w = w & ~wready;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] rs = RESP_OKAY);
    int n;
    qr.push_back({rs, m, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    tmo(n);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      re = qr.pop_front();
      chk({rresp, rdata & re[63:32]}, {re[65:64], re[31:0] & re[63:32]});
    end
    if (bvalid && bready) chk(34'(bresp), 34'(qb.pop_front()));
  end
  initial begin
    void'($urandom(32'h0773CDDC));
    ext <= 16'($urandom_range(6000));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h64, 32'h000003E8);
    rd(8'h68, 32'h00000064);
    rd(8'h80, 32'h00000000);
    rd(8'h88, 32'h00000000, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h88, 32'h00000001, RESP_SLVERR);
    for (int i = 0; i < 3; i++) wr(8'h48 + 8'(4 * i), 32'h00000004);
    wr(8'h40, 32'h00000004);
    for (int i = 0; i < 8; i++) begin
      pv[i] = 16'($urandom_range(5999));
      wr(8'(4 * i), {16'h0000, pv[i]});
    end
    for (int i = 0; i < 8; i++) begin
      want <= 3'(i);
      repeat (4) @(posedge aclk);
      chk({pidx, freq}, {3'(i), pv[i]});
      rd(8'h84, {pv[i], 11'h000, 1'b1, 1'(i >> 1), 3'(i)});
    end
    wr(8'h50, 32'h00000005);
    want <= 3'b101;
    repeat (4) @(posedge aclk);
    rd(8'h84, {pv[1], 11'h000, 1'b1, 1'b1, 3'b001});
    wr(8'h40, 32'h00000000);
    rd(8'h84, {ext, 16'h0000}, 32'hFFFF0010);
    tv = $urandom;
    wr(8'h40, 32'h00000009);
    wr(8'h44, 32'h00000001);
    wr(8'h24, tv);
    repeat (2) @(posedge aclk);
    chk({pval, ptgt}, {1'b1, tv});
    wr(8'h44, 32'h00000000);
    repeat (2) @(posedge aclk);
    chk(34'(pval), 34'h0);
    wr(8'h40, 32'h00000004);
    jog_want <= 1'b1;
    rd(8'h84, 32'h03E80040, 32'hFFFF0048);
    chk({r2, acc, dec}, {1'b0, 16'h0064, 16'h0064});
    wr(8'h64, 32'h00002328);
    repeat (2) @(posedge aclk);
    chk(34'(freq), 34'h1770);
    wr(8'h68, 32'h00000000);
    repeat (2) @(posedge aclk);
    chk({acc, dec}, {16'h0001, 16'h0001});
    jog_want <= 1'b0;
    want <= 3'b010;
    repeat (4) @(posedge aclk);
    chk({r2, acc, dec}, {1'b1, 16'h00C8, 16'h00C8});
    want <= 3'b000;
    r = $urandom_range(6000, 1);
    s = $urandom_range(100);
    wr(8'h54, 32'(r));
    wr(8'h80, 32'(s));
    repeat (2) @(posedge aclk);
    chk({acc, sha}, {16'(r), 16'(r * s / 200)});
    chk({dec, shd}, {16'h0064, 16'(100 * s / 200)});
    wr(8'h80, 32'h00000000);
    repeat (2) @(posedge aclk);
    chk({sha, shd}, 34'h0);
    for (int i = 0; i < 6; i++) begin
      wr(8'h7C, {24'h000000, ds[i]});
      repeat (2) @(posedge aclk);
      chk({dben, dbp, duty & {7{dben}}}, {ds[i] != 8'h00, ds[i] == 8'h01, ds[i] == 8'h01 ?
          7'h05 : (ds[i] == 8'h02 ? 7'h64 : 7'(ds[i]))});
    end
    lv = 16'($urandom);
    wr(8'h74, {16'h0000, lv});
    for (int i = 0; i < 3; i++) begin
      wr(8'h78, 32'(i * 2 + 2));
      repeat (2) @(posedge aclk);
      chk(34'(lvl), i == 0 ? 34'h0 : 34'(lv));
    end
    wr(8'h70, 32'h00000002);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      bstart <= 1'b1;
      @(posedge aclk);
      bstart <= 1'b0;
      cnt = 0;
      repeat (40) begin
        @(posedge aclk);
        cnt += int'(dca);
      end
      chk(34'(cnt), k == 0 ? 34'(2 * BRK) : 34'd40);
      wr(8'h70, 32'h000003E7);
    end
    brel <= 1'b1;
    @(posedge aclk);
    brel <= 1'b0;
    @(posedge aclk);
    chk(34'(dca), 34'h0);
    close_out();
  end
endmodule
bind psrbs_top psrbs_checker psrbs_checker_i (.aclk(aclk), .aresetn(aresetn), .jog_cmd(jog_cmd),
  .brake_start(brake_start), .brake_release(brake_release), .ramp_set2_r(ramp_set2_r),
  .accel_time_r(accel_time_r), .decel_time_r(decel_time_r), .s_half_accel_r(s_half_accel_r),
  .s_half_decel_r(s_half_decel_r), .dc_brake_active_r(dc_brake_active_r),
  .db_enable_r(db_enable_r), .db_duty_limit_r(db_duty_limit_r),
  .db_overload_protect_r(db_overload_protect_r));
`default_nettype wire
